/* hw/lpt_consts.svh */
// constants for the line pickup trip logic
//
// Behaviour
// - line dead (both detectors reset) runs arming timer; pickup-enable after 150 ms.
// - fault-current term is pickup current detector while pickup-enable is set.
// - bypass selected: trip in the same cycle the fault term becomes true.
// - bypass off: trip once fault term has held for 45 ms.
// - immediate or delayed trip comes from a stored setting input, not a link.
// - open pole holds the function disabled: no arming, no trip.
// - voltage present 25 ms fast-resets arming timer and drops pickup-enable.
// - second-zone phase or ground output with pickup-enable also trips.
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH

// ****************************************************************
// time base
// ****************************************************************
`define LPT_CLK_HZ        20000000
`define LPT_MS_PER_S      1000
`define LPT_CYCLES_PER_MS (`LPT_CLK_HZ / `LPT_MS_PER_S)

// ****************************************************************
// delays in milliseconds
// ****************************************************************
`define LPT_ARM_MS        150
`define LPT_TRIP_DLY_MS   45
`define LPT_LIVE_MS       25

// ****************************************************************
// synchroniser bit positions
// ****************************************************************
`define LPT_IN_OB         0
`define LPT_IN_V1         1
`define LPT_IN_I1         2
`define LPT_IN_POLE       3
`define LPT_IN_Z2PH       4
`define LPT_IN_Z2GND      5
`define LPT_IN_BYP        6
`define LPT_IN_NUM        7

`endif

/* hw/lpt_ms_tick.sv */
// millisecond enable pulse divided from the logic clock
`timescale 1ns/1ps
`default_nettype none
`include "lpt_consts.svh"

module lpt_ms_tick #(
  parameter int CYCLES_PER_MS = `LPT_CYCLES_PER_MS
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam int W = $clog2(CYCLES_PER_MS + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES_PER_MS - 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + W'(1);
    if (cnt == LAST) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  // one-cycle pulse every CYCLES_PER_MS clocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

  a_tick_single: assert property (@(posedge clk_in) disable iff (rst_in)
    tick_out |=> !tick_out)
    else $error("ms tick longer than one cycle");

endmodule

`default_nettype wire

/* hw/lpt_pkg.sv */
// types and helpers of the line pickup trip logic
`default_nettype none
`include "lpt_consts.svh"

package lpt_pkg;

  typedef logic [7:0]               lpt_cnt_t;
  typedef logic [`LPT_IN_NUM-1:0]   lpt_in_t;

  // registered state of the trip logic, apart from the millisecond tick divider
  typedef struct packed {
    lpt_in_t  sync1;
    lpt_in_t  sync2;
    lpt_cnt_t arm_cnt;
    logic     armed;
    lpt_cnt_t live_cnt;
    lpt_cnt_t dly_cnt;
  } lpt_state_s;

  // saturating step of a millisecond counter
  function automatic lpt_cnt_t lpt_sat_inc(input lpt_cnt_t c,
                                           input lpt_cnt_t lim);
    lpt_cnt_t r;
    r = c;
    if (c < lim) begin
      r = c + 8'h01;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

/* hw/lpt_trip_logic.sv */
// switch-onto-fault line pickup trip logic
`timescale 1ns/1ps
`default_nettype none
`include "lpt_consts.svh"

module lpt_trip_logic #(
  parameter int CYCLES_PER_MS = `LPT_CYCLES_PER_MS
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic open_breaker_detector_in,
  input  wire logic pos_seq_voltage_detector_in,
  input  wire logic pickup_current_detector_in,
  input  wire logic pole_open_in,
  input  wire logic zone2_phase_in,
  input  wire logic zone2_ground_in,
  input  wire logic trip_delay_bypass_select_in,
  output logic      pickup_enable_out,
  output logic      trip_out
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam lpt_pkg::lpt_cnt_t ARM_TICKS  = 8'(`LPT_ARM_MS);
  localparam lpt_pkg::lpt_cnt_t TRIP_TICKS = 8'(`LPT_TRIP_DLY_MS);
  localparam lpt_pkg::lpt_cnt_t LIVE_TICKS = 8'(`LPT_LIVE_MS);

  // ****************************************************************
  // state
  // ****************************************************************
  lpt_pkg::lpt_state_s st;
  lpt_pkg::lpt_state_s next_st;
  lpt_pkg::lpt_in_t    raw_in;
  logic                ms_tick;

  logic ob;
  logic v1;
  logic i1;
  logic pole;
  logic zone2;
  logic bypass;
  logic line_dead;
  logic live_expired;
  logic fault_term;
  logic delay_done;
  logic current_trip;
  logic zone2_trip;

  // ****************************************************************
  // millisecond time base
  // ****************************************************************
  lpt_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (ms_tick)
  );

  // ****************************************************************
  // pin inputs
  // ****************************************************************
  always_comb begin
    raw_in                  = '0;
    raw_in[`LPT_IN_OB]      = open_breaker_detector_in;
    raw_in[`LPT_IN_V1]      = pos_seq_voltage_detector_in;
    raw_in[`LPT_IN_I1]      = pickup_current_detector_in;
    raw_in[`LPT_IN_POLE]    = pole_open_in;
    raw_in[`LPT_IN_Z2PH]    = zone2_phase_in;
    raw_in[`LPT_IN_Z2GND]   = zone2_ground_in;
    raw_in[`LPT_IN_BYP]     = trip_delay_bypass_select_in;
  end

  // only the second synchroniser stage is read by logic
  assign ob     = st.sync2[`LPT_IN_OB];
  assign v1     = st.sync2[`LPT_IN_V1];
  assign i1     = st.sync2[`LPT_IN_I1];
  assign pole   = st.sync2[`LPT_IN_POLE];
  assign zone2  = st.sync2[`LPT_IN_Z2PH] | st.sync2[`LPT_IN_Z2GND];
  assign bypass = st.sync2[`LPT_IN_BYP];

  // ****************************************************************
  // combinational terms
  // ****************************************************************
  assign line_dead    = !ob && !v1;
  assign live_expired = st.live_cnt >= LIVE_TICKS;
  assign delay_done   = st.dly_cnt >= TRIP_TICKS;

  // open pole masks the enable, so nothing can trip
  assign pickup_enable_out = st.armed && !pole;
  assign fault_term        = pickup_enable_out && i1;

  // bypass from the stored setting trips at once
  assign current_trip = fault_term && (bypass || delay_done);
  assign zone2_trip   = pickup_enable_out && zone2;
  assign trip_out     = current_trip || zone2_trip;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st       = st;
    next_st.sync1 = raw_in;
    next_st.sync2 = st.sync1;

    // live-line timer runs while voltage is present
    if (!v1) begin
      next_st.live_cnt = '0;
    end else if (ms_tick) begin
      next_st.live_cnt = lpt_pkg::lpt_sat_inc(st.live_cnt, LIVE_TICKS);
    end

    // arming timer with fast reset and pole-open disable
    if (pole || live_expired) begin
      next_st.arm_cnt = '0;
      next_st.armed   = 1'b0;
    end else if (line_dead) begin
      if (ms_tick) begin
        next_st.arm_cnt = lpt_pkg::lpt_sat_inc(st.arm_cnt, ARM_TICKS);
      end
      if (st.arm_cnt >= ARM_TICKS) begin
        next_st.armed = 1'b1;
      end
    end else if (!st.armed) begin
      // line not dead before arming completed: start over
      next_st.arm_cnt = '0;
    end

    // trip-delay timer runs while the fault term holds
    if (!fault_term) begin
      next_st.dly_cnt = '0;
    end else if (ms_tick) begin
      next_st.dly_cnt = lpt_pkg::lpt_sat_inc(st.dly_cnt, TRIP_TICKS);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_arm_needs_dead: assert property (
    $rose(pickup_enable_out) |-> $past(line_dead) &&
      $past(st.arm_cnt) >= ARM_TICKS)
    else $error("pickup enable rose without full dead-line time");

  a_fault_term_def: assert property (
    fault_term == (pickup_enable_out &&
      $past(pickup_current_detector_in, 2)))
    else $error("fault term differs from enable and current");

  a_bypass_trip_now: assert property (
    bypass && fault_term |-> trip_out)
    else $error("bypass trip not immediate");

  a_delayed_trip: assert property (
    !bypass && !zone2_trip && trip_out |->
      st.dly_cnt >= TRIP_TICKS && $past(fault_term))
    else $error("delayed trip before trip delay");

  a_pole_blocks: assert property (
    pole |-> !pickup_enable_out && !trip_out ##1 !st.armed)
    else $error("function active with pole open");

  a_live_reset: assert property (
    live_expired |=> !pickup_enable_out && st.arm_cnt == 8'h00)
    else $error("live line did not fast-reset arming");

  a_zone2_trip: assert property (
    pickup_enable_out && zone2 |-> trip_out)
    else $error("second-zone trip missing");

  a_trip_cause: assert property (
    trip_out |-> pickup_enable_out && (i1 || zone2))
    else $error("trip without cause");

  a_timers_bound: assert property (
    st.arm_cnt <= ARM_TICKS && st.live_cnt <= LIVE_TICKS &&
      st.dly_cnt <= TRIP_TICKS)
    else $error("timer beyond its limit");

  a_arm_hold: assert property (
    st.armed && !pole && !live_expired |=> st.armed)
    else $error("arming dropped without pole open or live line");

  a_delay_restart: assert property (
    !fault_term |=> st.dly_cnt == 8'h00)
    else $error("trip delay not restarted");

  a_pole_pin_mask: assert property (
    $past(pole_open_in, 2) |-> !pickup_enable_out && !trip_out)
    else $error("open pole pin did not mask the function");

  a_zone2_pin_trip: assert property (
    pickup_enable_out && ($past(zone2_phase_in, 2) ||
      $past(zone2_ground_in, 2)) |-> trip_out)
    else $error("zone-2 pin did not trip");

  a_bypass_pin_trip: assert property (
    pickup_enable_out && $past(pickup_current_detector_in, 2) &&
      $past(trip_delay_bypass_select_in, 2) |-> trip_out)
    else $error("bypassed current trip not immediate");

  a_arm_drop_cause: assert property (
    $fell(st.armed) && !$past(pole) && !$past(rst_in) |->
      $past(live_expired))
    else $error("arming dropped without live-line expiry");

  c_arm: cover property ($rose(pickup_enable_out));
  c_delay_trip: cover property (!bypass && $rose(trip_out));
  c_bypass_trip: cover property (bypass && $rose(trip_out));
  c_live_out: cover property (st.armed ##1 live_expired ##1 !st.armed);
  c_pole_drop: cover property (st.armed && pole);

endmodule

`default_nettype wire

/* sim/lpt_line_model.sv */
// far-side model: breaker, line state and distance detector outputs
`timescale 1ns/1ps
`default_nettype none

module lpt_line_model (
  input  wire logic       energise_in,
  input  wire logic       bolted_in,
  input  wire logic       pole_in,
  input  wire logic [1:0] zone2_in,
  output wire logic       ob_out,
  output wire logic       v1_out,
  output wire logic       i1_out,
  output wire logic       pole_out,
  output wire logic       z2ph_out,
  output wire logic       z2gnd_out
);
  // ******************************************************
  // detectors
  // ******************************************************
  // the breaker detector follows energise_in alone
  assign ob_out    = energise_in;
  // a bolted fault holds the voltage at zero
  assign v1_out    = energise_in & ~bolted_in;
  assign i1_out    = energise_in & bolted_in;
  assign pole_out  = pole_in;
  assign z2ph_out  = zone2_in[0];
  assign z2gnd_out = zone2_in[1];
endmodule

`default_nettype wire

/* sim/test_lpt_trip_logic.sv */
// self-checking bench of the line pickup trip logic
`timescale 1ns/1ps
`default_nettype none

module test_lpt_trip_logic;
  localparam int CPM = 4;
  logic       clk_in   = 1'b0;
  logic       rst_in   = 1'b1;
  logic       energise = 1'b0;
  logic       bolted   = 1'b0;
  logic       pole     = 1'b0;
  logic [1:0] zone2    = 2'h0;
  logic       bypass   = 1'b0;
  wire logic  ob, v1, i1, po, zph, zgd;
  logic       pe;
  logic       trip;
  int         failures = 0;
  int         n_checks = 0;
  int         cycles   = 0;

  lpt_line_model u_line (.energise_in(energise), .bolted_in(bolted),
    .pole_in(pole), .zone2_in(zone2), .ob_out(ob), .v1_out(v1),
    .i1_out(i1), .pole_out(po), .z2ph_out(zph), .z2gnd_out(zgd));

  lpt_trip_logic #(.CYCLES_PER_MS(CPM)) u_dut (.clk_in(clk_in),
    .rst_in(rst_in), .open_breaker_detector_in(ob),
    .pos_seq_voltage_detector_in(v1), .pickup_current_detector_in(i1),
    .pole_open_in(po), .zone2_phase_in(zph), .zone2_ground_in(zgd),
    .trip_delay_bypass_select_in(bypass), .pickup_enable_out(pe),
    .trip_out(trip));

  // ******************************************************
  // clock, timeout and helpers
  // ******************************************************
  always #25 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic wait_ms(input int n);
    wait_cy(n * CPM);
  endtask

  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic arm_dead_line;
    wait_ms(148);
    chk(pe, 1'b0, "armed too early");
    wait_ms(5);
    chk(pe, 1'b1, "not armed on dead line");
  endtask

  task automatic delayed_trip;
    energise = 1'b1;
    bolted   = 1'b1;
    wait_ms(20);
    energise = 1'b0;
    bolted   = 1'b0;
    wait_cy(3);
    chk(trip, 1'b0, "trip after short fault");
    energise = 1'b1;
    bolted   = 1'b1;
    wait_ms(43);
    chk(trip, 1'b0, "delayed trip too early");
    wait_ms(4);
    chk(trip, 1'b1, "delayed trip missing");
    energise = 1'b0;
    bolted   = 1'b0;
    wait_cy(3);
    chk(trip, 1'b0, "trip held without current");
  endtask

  task automatic fast_trip;
    bypass = 1'b1;
    wait_cy(3);
    energise = 1'b1;
    bolted   = 1'b1;
    wait_cy(1);
    chk(trip, 1'b0, "trip before inputs synchronised");
    wait_cy(1);
    chk(trip, 1'b1, "bypassed trip delayed");
    energise = 1'b0;
    bolted   = 1'b0;
    wait_cy(3);
  endtask

  task automatic zone2_trip;
    for (int k = 0; k < 2; k++) begin
      zone2 = 2'h1 << k;
      wait_cy(3);
      chk(trip, 1'b1, "zone-2 trip missing");
      zone2 = 2'h0;
      wait_cy(3);
      chk(trip, 1'b0, "zone-2 trip held");
    end
  endtask

  task automatic live_reset;
    energise = 1'b1;
    wait_ms(23);
    chk(pe, 1'b1, "enable dropped early");
    wait_ms(4);
    chk(pe, 1'b0, "enable held on live line");
    energise = 1'b0;
    arm_dead_line();
  endtask

  task automatic pole_block;
    pole = 1'b1;
    wait_cy(3);
    chk(pe, 1'b0, "enable with open pole");
    energise = 1'b1;
    bolted   = 1'b1;
    zone2    = 2'h3;
    wait_cy(3);
    chk(trip, 1'b0, "trip with open pole");
    zone2 = 2'h0;
    pole  = 1'b0;
    wait_cy(3);
    chk(pe, 1'b0, "arming survived open pole");
    chk(trip, 1'b0, "trip after open pole");
    energise = 1'b0;
    bolted   = 1'b0;
    pole     = 1'b1;
    wait_ms(155);
    chk(pe, 1'b0, "armed with open pole");
  endtask

  initial begin
    wait_cy(16);
    rst_in = 1'b0;
    wait_cy(1);
    chk(pe, 1'b0, "enable after reset");
    chk(trip, 1'b0, "trip after reset");
    arm_dead_line();
    delayed_trip();
    fast_trip();
    zone2_trip();
    live_reset();
    pole_block();
    give_verdict();
  end
endmodule

`default_nettype wire
